//--- verilog/ims_pkg.sv
`default_nettype none
// ---------------------------------------------------------------
// Shared constants of the two-wire master sequencer
// ---------------------------------------------------------------
package ims_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_BAUD = 8'h0c;
	// Control register field positions
	localparam int CTL_START = 0;
	localparam int CTL_RESTART = 1;
	localparam int CTL_STOP = 2;
	localparam int CTL_RCV = 3;
	localparam int CTL_ACKSEQ = 4;
	localparam int CTL_ACKVAL = 5;
	// Status register field positions
	localparam int STA_BF = 0;
	localparam int STA_ACK = 1;
	localparam int STA_SDET = 2;
	localparam int STA_PIF = 3;
	localparam int STA_WRITE_COLLISION = 4;
	localparam int STA_OVF = 5;
	localparam int STA_BCOL = 6;
	localparam int STA_BUSY = 7;
	// Reset values
	localparam logic [7:0] RST_BAUD = 8'h09;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_BITS = 4'h0;
	// Bit counts of a byte frame
	localparam logic [3:0] BIT_LAST_DATA = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	// AHB encodings
	localparam logic [2:0] HSIZE_WORD = 3'b010;
	// Sequencer states
	typedef enum logic [3:0] {
		IMS_IDLE = 4'b0000,
		IMS_ST_WAIT = 4'b0001,
		IMS_ST_HOLD = 4'b0010,
		IMS_RS_LOW = 4'b0011,
		IMS_RS_SDAREL = 4'b0100,
		IMS_RS_SCLREL = 4'b0101,
		IMS_RS_HIGH = 4'b0110,
		IMS_RS_SDALOW = 4'b0111,
		IMS_TX_LOW = 4'b1000,
		IMS_TX_WAITH = 4'b1001,
		IMS_TX_HIGH = 4'b1010,
		IMS_RX_LOW = 4'b1011,
		IMS_RX_WAITH = 4'b1100,
		IMS_RX_HIGH = 4'b1101
	} ims_state_e;
endpackage : ims_pkg
`default_nettype wire

//--- verilog/ims_i2c_master.sv
// Overview of operation
// - Start request with idle lines loads baud counter
// - Expiry with lines high drives data low
// - Second period ends start, clears request
// - Low line at or during start collides
// - Restart request honoured only when idle
// - Restart: clock low, release data, release clock
// - Both high one period, data low, clock low
// - Restart sets start flag, interrupt after expiry
// - Restart collides: data low, clock falls
// - Buffer write sets full, starts bit clocking
// - Eighth falling edge clears full, releases data
// - Ninth clock data level becomes ack status
// - After ninth clock interrupt, clock held low
// - Busy buffer write discarded, collision flag set
// - Receive enable ignored unless port idle
// - Receive toggles clock, shifts data in
// - Eighth receive edge stores byte, goes idle
// - Buffer read clears full flag on receive
// - Overflow when byte completes with buffer full
// - Start completion raises interrupt before address write
// - First byte: address bits then direction bit
// - Released clock counted only once sampled high
`timescale 1ns/1ps
`default_nettype none
module ims_i2c_master (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n
);
	import ims_pkg::*;

	// ---------------------------------------------------------------
	// State record
	// ---------------------------------------------------------------
	typedef struct packed {
		ims_state_e st;
		logic [7:0] cnt;
		logic [3:0] bitcnt;
		logic [7:0] shift;
		logic [7:0] data;
		logic [7:0] reload;
		logic start_req;
		logic rs_req;
		logic rcv_en;
		logic ack_val;
		logic ack_stat;
		logic bf;
		logic write_collision;
		logic ovf;
		logic pif;
		logic bcol;
		logic sdet;
		logic scl_oe_n;
		logic sda_oe_n;
		logic scl_m;
		logic scl_s;
		logic sda_m;
		logic sda_s;
		logic dp_wr;
		logic [7:0] dp_addr;
		logic [31:0] hrdata;
		logic hready;
	} ims_reg_s;

	ims_reg_s q_ff;
	ims_reg_s nxt_q;

	// Address match on a word offset
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
		reg_hit = (addr == ofs);
	endfunction : reg_hit

	logic scl_hi;
	logic sda_hi;
	logic brg_zero;
	logic acc;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_data;
	logic wr_baud;
	logic coll;
	logic tx_busy;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		nxt_q = q_ff;
		coll = 1'b0;
		// Two-stage line synchronisers
		nxt_q.scl_m = scl_in;
		nxt_q.scl_s = q_ff.scl_m;
		nxt_q.sda_m = sda_in;
		nxt_q.sda_s = q_ff.sda_m;
		scl_hi = q_ff.scl_s;
		sda_hi = q_ff.sda_s;
		brg_zero = (q_ff.cnt == 8'h00);
		tx_busy = (q_ff.st == IMS_TX_LOW) || (q_ff.st == IMS_TX_WAITH) || (q_ff.st == IMS_TX_HIGH);

		// Bus address phase, zero wait states
		acc = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
		nxt_q.dp_wr = acc && hwrite;
		nxt_q.dp_addr = haddr[7:0];
		nxt_q.hready = 1'b1;
		if (acc && !hwrite) begin
			if (reg_hit(haddr[7:0], OFS_CTRL)) begin
				nxt_q.hrdata = {26'h0, q_ff.ack_val, 1'b0, q_ff.rcv_en, 1'b0, q_ff.rs_req, q_ff.start_req};
			end else if (reg_hit(haddr[7:0], OFS_STAT)) begin
				nxt_q.hrdata = {24'h0, (q_ff.st != IMS_IDLE), q_ff.bcol, q_ff.ovf, q_ff.write_collision,
					q_ff.pif, q_ff.sdet, q_ff.ack_stat, q_ff.bf};
			end else if (reg_hit(haddr[7:0], OFS_DATA)) begin
				nxt_q.hrdata = {24'h0, q_ff.data};
				if (!tx_busy) begin
					nxt_q.bf = 1'b0;
				end
			end else if (reg_hit(haddr[7:0], OFS_BAUD)) begin
				nxt_q.hrdata = {24'h0, q_ff.reload};
			end else begin
				nxt_q.hrdata = 32'h0;
			end
		end

		// Bus data phase writes
		wr_ctrl = q_ff.dp_wr && reg_hit(q_ff.dp_addr, OFS_CTRL);
		wr_stat = q_ff.dp_wr && reg_hit(q_ff.dp_addr, OFS_STAT);
		wr_data = q_ff.dp_wr && reg_hit(q_ff.dp_addr, OFS_DATA);
		wr_baud = q_ff.dp_wr && reg_hit(q_ff.dp_addr, OFS_BAUD);
		if (wr_baud) begin
			nxt_q.reload = hwdata[7:0];
		end
		if (wr_ctrl) begin
			nxt_q.ack_val = hwdata[CTL_ACKVAL];
		end
		// Write one to clear, placed before sets so a set wins
		if (wr_stat) begin
			nxt_q.sdet = q_ff.sdet & ~hwdata[STA_SDET];
			nxt_q.pif = q_ff.pif & ~hwdata[STA_PIF];
			nxt_q.write_collision = q_ff.write_collision & ~hwdata[STA_WRITE_COLLISION];
			nxt_q.ovf = q_ff.ovf & ~hwdata[STA_OVF];
			nxt_q.bcol = q_ff.bcol & ~hwdata[STA_BCOL];
		end
		if (wr_data && (q_ff.st != IMS_IDLE)) begin
			nxt_q.write_collision = 1'b1;
		end

		// Baud period countdown, frozen outside timed states
		if (!brg_zero && (q_ff.st inside {IMS_ST_WAIT, IMS_ST_HOLD, IMS_RS_SDAREL, IMS_RS_HIGH,
			IMS_RS_SDALOW, IMS_TX_LOW, IMS_TX_HIGH, IMS_RX_LOW, IMS_RX_HIGH})) begin
			nxt_q.cnt = q_ff.cnt - 8'h01;
		end

		// Sequencer
		case (q_ff.st)
			IMS_IDLE: begin
				if (wr_ctrl && hwdata[CTL_START]) begin
					nxt_q.start_req = 1'b1;
					if (!scl_hi || !sda_hi) begin
						coll = 1'b1;
					end else begin
						nxt_q.cnt = q_ff.reload;
						nxt_q.st = IMS_ST_WAIT;
					end
				end else if (wr_ctrl && hwdata[CTL_RESTART]) begin
					nxt_q.rs_req = 1'b1;
					nxt_q.scl_oe_n = 1'b0;
					nxt_q.st = IMS_RS_LOW;
				end else if (wr_ctrl && hwdata[CTL_RCV]) begin
					nxt_q.rcv_en = 1'b1;
					nxt_q.scl_oe_n = 1'b0;
					nxt_q.sda_oe_n = 1'b1;
					nxt_q.bitcnt = RST_BITS;
					nxt_q.cnt = q_ff.reload;
					nxt_q.st = IMS_RX_LOW;
				end else if (wr_data && !q_ff.write_collision) begin
					nxt_q.data = hwdata[7:0];
					nxt_q.shift = hwdata[7:0];
					nxt_q.bf = 1'b1;
					nxt_q.scl_oe_n = 1'b0;
					nxt_q.sda_oe_n = hwdata[7];
					nxt_q.bitcnt = RST_BITS;
					nxt_q.cnt = q_ff.reload;
					nxt_q.st = IMS_TX_LOW;
				end
			end
			IMS_ST_WAIT: begin
				if (!scl_hi) begin
					coll = 1'b1;
				end else if (brg_zero) begin
					if (!sda_hi) begin
						coll = 1'b1;
					end else begin
						nxt_q.sda_oe_n = 1'b0;
						nxt_q.sdet = 1'b1;
						nxt_q.cnt = q_ff.reload;
						nxt_q.st = IMS_ST_HOLD;
					end
				end
			end
			IMS_ST_HOLD: begin
				if (brg_zero) begin
					nxt_q.start_req = 1'b0;
					nxt_q.pif = 1'b1;
					nxt_q.st = IMS_IDLE;
				end
			end
			IMS_RS_LOW: begin
				if (!scl_hi) begin
					nxt_q.cnt = q_ff.reload;
					nxt_q.sda_oe_n = 1'b1;
					nxt_q.st = IMS_RS_SDAREL;
				end
			end
			IMS_RS_SDAREL: begin
				if (brg_zero) begin
					if (sda_hi) begin
						nxt_q.scl_oe_n = 1'b1;
						nxt_q.st = IMS_RS_SCLREL;
					end else begin
						coll = 1'b1;
					end
				end
			end
			IMS_RS_SCLREL: begin
				if (scl_hi) begin
					if (!sda_hi) begin
						coll = 1'b1;
					end else begin
						nxt_q.cnt = q_ff.reload;
						nxt_q.st = IMS_RS_HIGH;
					end
				end
			end
			IMS_RS_HIGH: begin
				if (!scl_hi || !sda_hi) begin
					coll = 1'b1;
				end else if (brg_zero) begin
					nxt_q.sda_oe_n = 1'b0;
					nxt_q.sdet = 1'b1;
					nxt_q.cnt = q_ff.reload;
					nxt_q.st = IMS_RS_SDALOW;
				end
			end
			IMS_RS_SDALOW: begin
				if (brg_zero) begin
					nxt_q.scl_oe_n = 1'b0;
					nxt_q.rs_req = 1'b0;
					nxt_q.pif = 1'b1;
					nxt_q.st = IMS_IDLE;
				end
			end
			IMS_TX_LOW: begin
				if (brg_zero) begin
					nxt_q.scl_oe_n = 1'b1;
					nxt_q.st = IMS_TX_WAITH;
				end
			end
			IMS_TX_WAITH: begin
				if (scl_hi) begin
					nxt_q.cnt = q_ff.reload;
					nxt_q.st = IMS_TX_HIGH;
					if (q_ff.bitcnt == BIT_ACK) begin
						nxt_q.ack_stat = sda_hi;
					end
				end
			end
			IMS_TX_HIGH: begin
				if (brg_zero) begin
					nxt_q.scl_oe_n = 1'b0;
					nxt_q.bitcnt = q_ff.bitcnt + 4'h1;
					if (q_ff.bitcnt == BIT_ACK) begin
						nxt_q.pif = 1'b1;
						nxt_q.st = IMS_IDLE;
					end else begin
						if (q_ff.bitcnt == BIT_LAST_DATA) begin
							nxt_q.bf = 1'b0;
							nxt_q.sda_oe_n = 1'b1;
						end else begin
							nxt_q.shift = {q_ff.shift[6:0], 1'b0};
							nxt_q.sda_oe_n = q_ff.shift[6];
						end
						nxt_q.cnt = q_ff.reload;
						nxt_q.st = IMS_TX_LOW;
					end
				end
			end
			IMS_RX_LOW: begin
				if (brg_zero) begin
					nxt_q.scl_oe_n = 1'b1;
					nxt_q.st = IMS_RX_WAITH;
				end
			end
			IMS_RX_WAITH: begin
				if (scl_hi) begin
					nxt_q.shift = {q_ff.shift[6:0], sda_hi};
					nxt_q.cnt = q_ff.reload;
					nxt_q.st = IMS_RX_HIGH;
				end
			end
			IMS_RX_HIGH: begin
				if (brg_zero) begin
					nxt_q.scl_oe_n = 1'b0;
					if (q_ff.bitcnt == BIT_LAST_DATA) begin
						nxt_q.rcv_en = 1'b0;
						nxt_q.data = q_ff.shift;
						nxt_q.bf = 1'b1;
						nxt_q.pif = 1'b1;
						nxt_q.st = IMS_IDLE;
						if (q_ff.bf) begin
							nxt_q.ovf = 1'b1;
						end
					end else begin
						nxt_q.bitcnt = q_ff.bitcnt + 4'h1;
						nxt_q.cnt = q_ff.reload;
						nxt_q.st = IMS_RX_LOW;
					end
				end
			end
			default: begin
				nxt_q.st = IMS_IDLE;
			end
		endcase

		// Collision abort: release lines, drop requests, go idle
		if (coll) begin
			nxt_q.bcol = 1'b1;
			nxt_q.scl_oe_n = 1'b1;
			nxt_q.sda_oe_n = 1'b1;
			nxt_q.start_req = 1'b0;
			nxt_q.rs_req = 1'b0;
			nxt_q.rcv_en = 1'b0;
			nxt_q.st = IMS_IDLE;
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			q_ff <= '0;
			q_ff.st <= IMS_IDLE;
			q_ff.reload <= RST_BAUD;
			q_ff.data <= RST_BYTE;
			q_ff.scl_oe_n <= 1'b1;
			q_ff.sda_oe_n <= 1'b1;
			q_ff.scl_m <= 1'b1;
			q_ff.scl_s <= 1'b1;
			q_ff.sda_m <= 1'b1;
			q_ff.sda_s <= 1'b1;
			q_ff.hready <= 1'b1;
		end else begin
			q_ff <= nxt_q;
		end
	end

	// Outputs straight from the state record
	assign hreadyout = q_ff.hready;
	assign hresp = q_ff.bcol & 1'b0;
	assign hrdata = q_ff.hrdata;
	// Open-drain pins only ever pull low; the first synchroniser stage is not read here
	assign scl_out = q_ff.scl_oe_n & 1'b0;
	assign sda_out = q_ff.sda_oe_n & 1'b0;
	assign scl_oe_n = q_ff.scl_oe_n;
	assign sda_oe_n = q_ff.sda_oe_n;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence start_go_s;
		q_ff.st == IMS_IDLE && wr_ctrl && hwdata[CTL_START] && scl_hi && sda_hi;
	endsequence
	sequence start_loaded_s;
		q_ff.st == IMS_ST_WAIT && q_ff.cnt == $past(q_ff.reload) && q_ff.start_req;
	endsequence
	start_load_a: assert property (start_go_s |=> start_loaded_s)
		else $error("start did not load baud counter");
	start_coll_a: assert property (q_ff.st == IMS_IDLE && wr_ctrl && hwdata[CTL_START] && !scl_hi
		|=> q_ff.bcol && q_ff.st == IMS_IDLE && !q_ff.start_req)
		else $error("start collision not flagged");
	start_done_a: assert property (q_ff.st == IMS_ST_HOLD && brg_zero
		|=> !q_ff.start_req && q_ff.pif && !q_ff.sda_oe_n && q_ff.st == IMS_IDLE)
		else $error("start completion wrong");
	rs_ignore_a: assert property (q_ff.st != IMS_IDLE && wr_ctrl && hwdata[CTL_RESTART] && !q_ff.rs_req
		&& q_ff.st != IMS_RS_LOW |=> !q_ff.rs_req)
		else $error("restart taken while busy");
	rs_pif_a: assert property (q_ff.st == IMS_RS_HIGH && brg_zero && scl_hi && sda_hi
		|=> q_ff.sdet && (q_ff.pif == $past(q_ff.pif)))
		else $error("restart flags out of order");
	buf_write_a: assert property (q_ff.st == IMS_IDLE && wr_data && !q_ff.write_collision && !wr_ctrl
		|=> q_ff.bf && q_ff.st == IMS_TX_LOW && !q_ff.scl_oe_n)
		else $error("buffer write did not start transmit");
	write_collision_set_a: assert property (tx_busy && wr_data
		|=> q_ff.write_collision && $stable(q_ff.data))
		else $error("busy write not discarded");
	tx_eighth_a: assert property (q_ff.st == IMS_TX_HIGH && brg_zero && q_ff.bitcnt == BIT_LAST_DATA
		|=> !q_ff.bf && q_ff.sda_oe_n && q_ff.st == IMS_TX_LOW)
		else $error("eighth edge did not release data");
	ack_cap_a: assert property (q_ff.st == IMS_TX_WAITH && scl_hi && q_ff.bitcnt == BIT_ACK
		|=> q_ff.ack_stat == $past(sda_hi))
		else $error("ack status not captured");
	tx_end_a: assert property (q_ff.st == IMS_TX_HIGH && brg_zero && q_ff.bitcnt == BIT_ACK
		|=> q_ff.pif && !q_ff.scl_oe_n && (q_ff.st == IMS_IDLE))
		else $error("ninth clock end wrong");
	rx_done_a: assert property (q_ff.st == IMS_RX_HIGH && brg_zero && q_ff.bitcnt == BIT_LAST_DATA
		|=> q_ff.bf && q_ff.pif && !q_ff.rcv_en && q_ff.data == $past(q_ff.shift))
		else $error("receive completion wrong");
	rx_ovf_a: assert property (q_ff.st == IMS_RX_HIGH && brg_zero && q_ff.bitcnt == BIT_LAST_DATA && q_ff.bf
		|=> q_ff.ovf)
		else $error("overflow not flagged");
	brg_freeze_a: assert property ((q_ff.st == IMS_TX_WAITH || q_ff.st == IMS_RX_WAITH) && !scl_hi
		|=> $stable(q_ff.cnt))
		else $error("counter ran while clock held low");
endmodule : ims_i2c_master
`default_nettype wire

//--- test/ims_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Behavioural two-wire slave on the far side of the lines
// ---------------------------------------------------------------
module ims_slave_model #(
	parameter logic [6:0] ADDR = 7'h52,
	parameter logic [7:0] TX_BYTE = 8'ha5
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic stretch,
	output logic sda_rel,
	output logic scl_rel,
	output logic [7:0] got
);
	logic [7:0] sh = 8'h00;
	logic first = 1'b0;
	logic rd = 1'b0;
	logic ack = 1'b0;
	int n = 0;
	int j = 0;
	// Released lines float high through the pull-up
	initial begin
		sda_rel = 1'b1;
		scl_rel = 1'b1;
		got = 8'h00;
	end
	// Start: data falls while the clock is high
	always @(negedge sda) begin
		if (scl) begin
			n = 0;
			first = 1'b1;
			rd = 1'b0;
		end
	end
	// Sample each bit on the rising clock, MSB first
	always @(posedge scl) begin
		if (n < 8) sh = {sh[6:0], sda};
		n = n + 1;
	end
	// Drive ack or read data after each fall, then maybe stretch
	always @(negedge scl) begin
		if (rd) begin
			j = j + 1;
			sda_rel = TX_BYTE[7 - (j % 8)];
		end else if (n == 8) begin
			got = sh;
			ack = !first || sh[7:1] == ADDR;
			sda_rel = !ack;
		end else if (n == 9) begin
			rd = first && sh[0] && ack;
			first = 1'b0;
			n = 0;
			j = 0;
			sda_rel = rd ? TX_BYTE[7] : 1'b1;
		end
		if (stretch) begin
			scl_rel = 1'b0;
			#600;
			scl_rel = 1'b1;
		end
	end
endmodule : ims_slave_model
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ims_pkg::*;
	typedef struct packed {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} ims_row_s;
	localparam ims_row_s ROWS [0:6] = '{'{OFS_CTRL, 1'b0, 8'h00, 8'h00}, '{OFS_STAT, 1'b0, 8'h00, 8'h00},
		'{OFS_DATA, 1'b0, 8'h00, 8'h00}, '{OFS_BAUD, 1'b0, 8'h00, RST_BAUD}, '{8'h10, 1'b1, 8'hff, 8'h00},
		'{OFS_BAUD, 1'b1, 8'h03, 8'h03}, '{OFS_STAT, 1'b1, 8'h7f, 8'h00}};
	localparam logic [6:0] SLV = 7'h52;
	logic clk_sys, rst_n, hsel, hwrite, hreadyout, hresp, scl_out, scl_oe_n, sda_out, sda_oe_n;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hold_scl, stretch, s_sda, s_scl;
	logic [7:0] got;
	wire scl, sda;
	int n_mismatch, cmp_count, lo_cnt, low_len;
	// Open-drain lines with pull-ups
	assign scl = scl_oe_n & s_scl & ~hold_scl;
	assign sda = sda_oe_n & s_sda;
	ims_i2c_master uut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
	ims_slave_model #(.ADDR(SLV)) slave (.scl(scl), .sda(sda), .stretch(stretch), .sda_rel(s_sda),
		.scl_rel(s_scl), .got(got));
	// ---------------------------------------------------------------
	// Clock, monitor and shared tasks
	// ---------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// Length of the last low phase the master drove on the clock line
	always @(posedge clk_sys) begin
		if (scl_oe_n === 1'b0) lo_cnt <= lo_cnt + 1;
		else begin
			if (lo_cnt != 0) low_len <= lo_cnt;
			lo_cnt <= 0;
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One single word transfer; read data lands in r
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= HSIZE_WORD;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		r = hrdata;
	endtask : bus
	// Poll status until the sequencer is idle
	task automatic wait_idle();
		r = '1;
		for (int k = 0; k < 300 && r[STA_BUSY] !== 1'b0; k++) bus(OFS_STAT, 1'b0, 8'h00);
	endtask : wait_idle
	task automatic finish_test();
		$display("counts: %0d compared, %0d mismatched", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : finish_test
	// Watchdog against a hung sequence
	initial begin
		#2000000;
		n_mismatch++;
		finish_test();
	end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{rst_n, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
		{hold_scl, stretch, n_mismatch, cmp_count, lo_cnt, low_len} = '0;
		repeat (12) @(posedge clk_sys);
		chk("reset ports", {hreadyout, hresp, scl_oe_n, sda_oe_n}, 4'b1011);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		foreach (ROWS[i]) begin
			if (ROWS[i].w) bus(ROWS[i].a, 1'b1, ROWS[i].d);
			bus(ROWS[i].a, 1'b0, 8'h00);
			chk("register", r, {24'h000000, ROWS[i].e});
		end
		// Start with the clock line held low by someone else
		hold_scl <= 1'b1;
		bus(OFS_CTRL, 1'b1, 8'h01);
		wait_idle();
		chk("start collision", r[STA_BCOL], 1'b1);
		chk("data released", sda_oe_n, 1'b1);
		bus(OFS_CTRL, 1'b0, 8'h00);
		chk("start aborted", r, 32'h0);
		hold_scl <= 1'b0;
		bus(OFS_STAT, 1'b1, 8'h7c);
		// Start, with restart and receive requested while busy
		bus(OFS_CTRL, 1'b1, 8'h01);
		bus(OFS_CTRL, 1'b1, 8'h0a);
		wait_idle();
		chk("start status", r[7:0], 8'h0c);
		chk("data held low", sda_oe_n, 1'b0);
		bus(OFS_CTRL, 1'b0, 8'h00);
		chk("start ctrl", r, 32'h0);
		bus(OFS_STAT, 1'b1, 8'h7c);
		// Address byte with a buffer write in mid-byte
		bus(OFS_DATA, 1'b1, {SLV, 1'b0});
		bus(OFS_STAT, 1'b0, 8'h00);
		chk("buffer full", r[STA_BF], 1'b1);
		bus(OFS_DATA, 1'b1, 8'hff);
		wait_idle();
		chk("addr status", r[7:0], 8'h18);
		chk("clock held", scl_oe_n, 1'b0);
		chk("addr byte", got, {SLV, 1'b0});
		bus(OFS_DATA, 1'b1, 8'h3c);
		bus(OFS_STAT, 1'b0, 8'h00);
		chk("write discarded", r[STA_BUSY], 1'b0);
		bus(OFS_STAT, 1'b1, 8'h7c);
		// Data byte with the slave stretching every low phase
		stretch <= 1'b1;
		bus(OFS_DATA, 1'b1, 8'h3c);
		bus(OFS_CTRL, 1'b1, 8'h08);
		wait_idle();
		stretch <= 1'b0;
		chk("data byte", got, 8'h3c);
		chk("data status", r[7:0], 8'h08);
		bus(OFS_CTRL, 1'b0, 8'h00);
		chk("receive ignored", r, 32'h0);
		// Restart, then an address nobody answers
		bus(OFS_STAT, 1'b1, 8'h7c);
		bus(OFS_CTRL, 1'b1, 8'h02);
		wait_idle();
		chk("restart status", r[7:0], 8'h0c);
		bus(OFS_CTRL, 1'b0, 8'h00);
		chk("restart ctrl", r, 32'h0);
		bus(OFS_STAT, 1'b1, 8'h7c);
		bus(OFS_DATA, 1'b1, {~SLV, 1'b0});
		wait_idle();
		chk("not acked", r[STA_ACK], 1'b1);
		chk("low phase", low_len, 4);
		// Restart into a read, two bytes without reading between
		bus(OFS_CTRL, 1'b1, 8'h02);
		wait_idle();
		bus(OFS_STAT, 1'b1, 8'h7c);
		bus(OFS_DATA, 1'b1, {SLV, 1'b1});
		wait_idle();
		chk("read addr", r[7:0], 8'h08);
		bus(OFS_STAT, 1'b1, 8'h7c);
		bus(OFS_CTRL, 1'b1, 8'h08);
		wait_idle();
		chk("rx status", r[7:0], 8'h09);
		bus(OFS_CTRL, 1'b0, 8'h00);
		chk("rx enable off", r, 32'h0);
		bus(OFS_CTRL, 1'b1, 8'h08);
		wait_idle();
		chk("overflow", r[STA_OVF], 1'b1);
		bus(OFS_DATA, 1'b0, 8'h00);
		chk("rx byte", r, 32'ha5);
		bus(OFS_STAT, 1'b0, 8'h00);
		chk("full cleared", r[STA_BF], 1'b0);
		// Software picks the acknowledge value after reading the byte
		bus(OFS_CTRL, 1'b1, 8'h20);
		bus(OFS_CTRL, 1'b0, 8'h00);
		chk("ack value", r, 32'h20);
		chk("line outputs", {hresp, scl_out, sda_out}, 3'b000);
		// Reset in mid-run releases the lines and clears the flags
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("mid reset lines", {scl_oe_n, sda_oe_n}, 2'b11);
		rst_n <= 1'b1;
		bus(OFS_STAT, 1'b0, 8'h00);
		chk("mid reset status", r, 32'h0);
		finish_test();
	end
endmodule : tb
`default_nettype wire
